/* File: gpb_bank.sv */
// pin configuration bank with axi4-lite register slave
`timescale 1ns/10ps
// How it works
// - dir enable pair selects pad mode
// - local value driven only as gp output
// - remote bit makes pin output remote value
// - port select moves pin0 register to alt0
// - port select moves pin1/2 register to alt1/2
// - port select moves pin3 register to alt3
// - pin0 resets as general purpose input
// - pin1/2 register resets to 0x3
// - pin3 register resets to 0x2, tri-state
// - pin5..8 registers reset to zero
// - high pin upper nibble, low pin lower
// - pin bits override global pin settings
// - port select lives in dual receive control
module gpb_bank #(
  parameter int ADDR_W = 12,
  parameter logic [3:0] REVISION = 4'h5 // arbitrary revision code
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input gpb_pkg::gpb_global_cfg_type global_cfg,
  input wire logic [gpb_pkg::NUM_PRI-1:0] func_out,
  input wire logic [gpb_pkg::NUM_ALT-1:0] alt_func_out,
  input wire logic [gpb_pkg::NUM_PRI-1:0] link_value,
  input wire logic link_valid,
  input wire logic [gpb_pkg::NUM_PRI-1:0] pad_in,
  output logic [gpb_pkg::NUM_PRI-1:0] pad_out,
  output logic [gpb_pkg::NUM_PRI-1:0] pad_oe_n,
  input wire logic [gpb_pkg::NUM_ALT-1:0] alt_pad_in,
  output logic [gpb_pkg::NUM_ALT-1:0] alt_pad_out,
  output logic [gpb_pkg::NUM_ALT-1:0] alt_pad_oe_n,
  output logic secondary_port_select
);
  import gpb_pkg::*;

  // configuration storage
  logic [3:0] pin0_config; // low nibble only, upper is revision
  logic [7:0] pin1_pin2_config; // both nibbles writable
  logic [3:0] pin3_config; // low nibble only, upper reserved
  logic [7:0] pin5_pin6_config; // both nibbles writable
  logic [7:0] pin7_pin8_config; // both nibbles writable

  // write channel holding state
  logic aw_held; // write address taken
  logic w_held; // write data taken
  logic [9:0] aw_index; // held word index
  logic [7:0] w_byte; // held low data byte
  logic w_lane0; // held strobe of the low byte lane
  logic do_write; // both halves present, commit now
  logic wr_hit; // held index maps to a register
  logic [9:0] ar_index; // read word index
  logic [31:0] next_rdata; // read data mux
  logic rd_hit; // read index maps to a register

  // per pin configuration and remote values
  gpb_pin_cfg_type pri_cfg [NUM_PRI]; // configuration seen by primary pins
  gpb_pin_cfg_type alt_cfg [NUM_ALT]; // configuration seen by alternate pins
  gpb_pin_cfg_type reg_cfg [NUM_PRI]; // register nibble per primary slot
  gpb_pad_type pri_pad [NUM_PRI]; // primary pad drive
  gpb_pad_type alt_pad [NUM_ALT]; // alternate pad drive
  logic [NUM_PRI-1:0] remote_hold; // last value from the link
  logic [NUM_PRI-1:0] pri_level; // synchronised primary levels
  logic [NUM_ALT-1:0] alt_level; // synchronised alternate levels

  // write address and data ready only while the slot is free
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_index = s_axi_araddr[11:2];

  // decode of the held write index
  always_comb begin
    case (aw_index)
      IDX_PIN0: wr_hit = 1'b1;
      IDX_PIN1_PIN2: wr_hit = 1'b1;
      IDX_PIN3: wr_hit = 1'b1;
      IDX_PIN5_PIN6: wr_hit = 1'b1;
      IDX_PIN7_PIN8: wr_hit = 1'b1;
      IDX_DUAL_RX: wr_hit = 1'b1;
      // level register is read-only, write answers okay and is dropped
      IDX_PIN_LEVEL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // capture write address, independent of data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[11:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // capture write data, independent of address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pin 0 register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin0_config <= RST_PIN0;
    end else if (do_write && w_lane0 && aw_index == IDX_PIN0) begin
      pin0_config <= w_byte[LO_NIB +: NIB_W];
    end
  end

  // pins 1 and 2 register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_pin2_config <= RST_PIN1_PIN2;
    end else if (do_write && w_lane0 && aw_index == IDX_PIN1_PIN2) begin
      pin1_pin2_config <= w_byte;
    end
  end

  // pin 3 register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin3_config <= RST_PIN3;
    end else if (do_write && w_lane0 && aw_index == IDX_PIN3) begin
      pin3_config <= w_byte[LO_NIB +: NIB_W];
    end
  end

  // pins 5..8 registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin5_pin6_config <= RST_PIN5_PIN6;
      pin7_pin8_config <= RST_PIN7_PIN8;
    end else if (do_write && w_lane0) begin
      if (aw_index == IDX_PIN5_PIN6) begin
        pin5_pin6_config <= w_byte;
      end
      if (aw_index == IDX_PIN7_PIN8) begin
        pin7_pin8_config <= w_byte;
      end
    end
  end

  // dual receive control, port select bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secondary_port_select <= RST_PORT_SEL;
    end else if (do_write && w_lane0 && aw_index == IDX_DUAL_RX) begin
      secondary_port_select <= w_byte[PORT_SEL_POS];
    end
  end

  // read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ar_index)
      IDX_PIN0: begin
        next_rdata[REV_POS +: NIB_W] = REVISION;
        next_rdata[LO_NIB +: NIB_W] = pin0_config;
      end
      IDX_PIN1_PIN2: next_rdata[7:0] = pin1_pin2_config;
      IDX_PIN3: next_rdata[LO_NIB +: NIB_W] = pin3_config;
      IDX_PIN5_PIN6: next_rdata[7:0] = pin5_pin6_config;
      IDX_PIN7_PIN8: next_rdata[7:0] = pin7_pin8_config;
      IDX_DUAL_RX: next_rdata[PORT_SEL_POS] = secondary_port_select;
      IDX_PIN_LEVEL: begin
        next_rdata[NUM_PRI-1:0] = pri_level;
        next_rdata[ALT_LEVEL_POS +: NUM_ALT] = alt_level;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel, data one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // remote values from the forward channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_hold <= '0;
    end else if (link_valid) begin
      remote_hold <= link_value;
    end
  end

  // nibble per primary slot: pin0,1,2,3,5,6,7,8
  always_comb begin
    reg_cfg[0] = gpb_pin_cfg_type'(pin0_config);
    reg_cfg[1] = gpb_pin_cfg_type'(pin1_pin2_config[LO_NIB +: NIB_W]);
    reg_cfg[2] = gpb_pin_cfg_type'(pin1_pin2_config[HI_NIB +: NIB_W]);
    reg_cfg[3] = gpb_pin_cfg_type'(pin3_config);
    reg_cfg[4] = gpb_pin_cfg_type'(pin5_pin6_config[LO_NIB +: NIB_W]);
    reg_cfg[5] = gpb_pin_cfg_type'(pin5_pin6_config[HI_NIB +: NIB_W]);
    reg_cfg[6] = gpb_pin_cfg_type'(pin7_pin8_config[LO_NIB +: NIB_W]);
    reg_cfg[7] = gpb_pin_cfg_type'(pin7_pin8_config[HI_NIB +: NIB_W]);
  end

  // steer lower registers to the selected port
  always_comb begin
    for (int i = 0; i < NUM_PRI; i++) begin
      pri_cfg[i] = reg_cfg[i];
    end
    for (int j = 0; j < NUM_ALT; j++) begin
      alt_cfg[j] = '0;
    end
    if (secondary_port_select) begin
      for (int k = 0; k < NUM_ALT; k++) begin
        alt_cfg[k] = reg_cfg[k];
        pri_cfg[k] = '0;
      end
    end
  end

  // primary pads
  for (genvar p = 0; p < NUM_PRI; p++) begin : g_pri
    gpb_pin u_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(pri_cfg[p]),
      .global_cfg(global_cfg),
      .func_out(func_out[p]),
      .remote_value(remote_hold[p]),
      .pad_in(pad_in[p]),
      .pad(pri_pad[p]),
      .level(pri_level[p])
    );
    assign pad_out[p] = pri_pad[p].out;
    assign pad_oe_n[p] = pri_pad[p].oe_n;
  end

  // alternate port pads
  for (genvar a = 0; a < NUM_ALT; a++) begin : g_alt
    gpb_pin u_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(alt_cfg[a]),
      .global_cfg(global_cfg),
      .func_out(alt_func_out[a]),
      .remote_value(remote_hold[a]),
      .pad_in(alt_pad_in[a]),
      .pad(alt_pad[a]),
      .level(alt_level[a])
    );
    assign alt_pad_out[a] = alt_pad[a].out;
    assign alt_pad_oe_n[a] = alt_pad[a].oe_n;
  end

endmodule

/* File: gpb_pkg.sv */
// constants, field layouts and carrier types for the pin configuration bank
package gpb_pkg;

  // register word indices; byte address is four times the index
  localparam logic [9:0] IDX_PIN0 = 10'h01d;
  localparam logic [9:0] IDX_PIN1_PIN2 = 10'h01e;
  localparam logic [9:0] IDX_PIN3 = 10'h01f;
  localparam logic [9:0] IDX_PIN5_PIN6 = 10'h020;
  localparam logic [9:0] IDX_PIN7_PIN8 = 10'h021;
  localparam logic [9:0] IDX_DUAL_RX = 10'h030;
  localparam logic [9:0] IDX_PIN_LEVEL = 10'h031;

  // reset values of the configuration registers
  localparam logic [3:0] RST_PIN0 = 4'h3;
  localparam logic [7:0] RST_PIN1_PIN2 = 8'h03;
  localparam logic [3:0] RST_PIN3 = 4'h2;
  localparam logic [7:0] RST_PIN5_PIN6 = 8'h00;
  localparam logic [7:0] RST_PIN7_PIN8 = 8'h00;
  localparam logic RST_PORT_SEL = 1'b0;

  // field positions inside a byte or a register word
  localparam int LO_NIB = 0;
  localparam int HI_NIB = 4;
  localparam int NIB_W = 4;
  localparam int REV_POS = 4;
  localparam int PORT_SEL_POS = 0;
  localparam int ALT_LEVEL_POS = 8;

  // decoded {direction, enable} pairs
  localparam logic [1:0] MODE_FUNC = 2'b00;
  localparam logic [1:0] MODE_TRI = 2'b10;
  localparam logic [1:0] MODE_GP_OUT = 2'b01;
  localparam logic [1:0] MODE_GP_IN = 2'b11;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // pin counts
  localparam int NUM_PRI = 8;
  localparam int NUM_ALT = 4;

  // one pin's configuration nibble, msb first
  typedef struct packed {
    logic value;
    logic remote;
    logic dir;
    logic en;
  } gpb_pin_cfg_type;

  // global pin configuration held outside this block
  typedef struct packed {
    logic value;
    logic dir;
    logic en;
  } gpb_global_cfg_type;

  // pad side of one pin
  typedef struct packed {
    logic out;
    logic oe_n;
  } gpb_pad_type;

endpackage

/* File: gpb_pin.sv */
// one pad: input synchroniser and output mux
`timescale 1ns/10ps
module gpb_pin (
  input wire logic aclk,
  input wire logic aresetn,
  input gpb_pkg::gpb_pin_cfg_type cfg,
  input gpb_pkg::gpb_global_cfg_type global_cfg,
  input wire logic func_out,
  input wire logic remote_value,
  input wire logic pad_in,
  output gpb_pkg::gpb_pad_type pad,
  output logic level
);
  import gpb_pkg::*;

  logic sync1; // first stage, read only by sync2
  logic sync2; // second stage
  logic sync3; // third stage
  logic next_out; // value to drive
  logic next_oe_n; // low to drive

  // three stage synchroniser on the pad input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= 1'b0;
    end else if (sync2 == sync3) begin
      level <= sync3;
    end
  end

  // output mux
  always_comb begin
    next_out = 1'b0;
    next_oe_n = 1'b1;
    if (cfg.remote) begin
      next_out = remote_value;
      next_oe_n = 1'b0;
    end else begin
      case ({cfg.dir, cfg.en})
        MODE_GP_OUT: begin
          next_out = cfg.value;
          next_oe_n = 1'b0;
        end
        MODE_GP_IN: begin
          next_oe_n = 1'b1;
        end
        MODE_TRI: begin
          next_oe_n = 1'b1;
        end
        MODE_FUNC: begin
          case ({global_cfg.dir, global_cfg.en})
            MODE_FUNC: begin
              next_out = func_out;
              next_oe_n = 1'b0;
            end
            MODE_GP_OUT: begin
              next_out = global_cfg.value;
              next_oe_n = 1'b0;
            end
            default: begin
              next_oe_n = 1'b1;
            end
          endcase
        end
        default: begin
          next_oe_n = 1'b1;
        end
      endcase
    end
  end

  // registered pad drive, released at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad.out <= 1'b0;
      pad.oe_n <= 1'b1;
    end else begin
      pad.out <= next_out;
      pad.oe_n <= next_oe_n;
    end
  end

endmodule

/* File: gpb_checker.sv */
// concurrent port checks for the pin configuration bank
`timescale 1ns/10ps
module gpb_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input gpb_pkg::gpb_global_cfg_type global_cfg,
  input wire logic [7:0] func_out,
  input wire logic [3:0] alt_func_out,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [3:0] alt_pad_out,
  input wire logic [3:0] alt_pad_oe_n,
  input wire logic secondary_port_select
);
  import gpb_pkg::*;
  // every check samples on the bus clock and sleeps in reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // write answer stands until taken
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  // address and data taken together: held one cycle, answer registered on the next edge
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read answer late");
  AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
    else $error("reserved read bits not zero");
  AST_ALT_GLOBAL: assert property (!secondary_port_select && global_cfg == 3'h0
    |=> alt_pad_oe_n == 4'h0 && alt_pad_out == $past(alt_func_out))
    else $error("alt pins not functional while deselected");
  AST_PRI_GLOBAL: assert property (secondary_port_select && global_cfg == 3'h0
    |=> pad_oe_n[3:0] == 4'h0 && pad_out[3:0] == $past(func_out[3:0]))
    else $error("primary pins not functional while alt selected");
  AST_PRI_TRI: assert property (secondary_port_select && global_cfg.dir
    |=> pad_oe_n[3:0] == 4'hf) else $error("primary pins driven while released");
  AST_GLOBAL_VAL: assert property (secondary_port_select && !global_cfg.dir && global_cfg.en
    |=> pad_oe_n[3:0] == 4'h0 && pad_out[3:0] == {4{$past(global_cfg.value)}})
    else $error("global output value not driven");
  AST_SEL_WR: assert property ($changed(secondary_port_select) |-> $rose(s_axi_bvalid))
    else $error("port select changed without a write");
endmodule

/* File: gpb_link_model.sv */
// remote serializer model: pulses pin values over the forward channel
`timescale 1ns/10ps
module gpb_link_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic send,
  input wire logic [7:0] sval,
  output logic [7:0] link_value,
  output logic link_valid
);
  // one valid pulse per send; between pulses the value lines scramble
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_valid <= 1'b0;
      link_value <= 8'h00;
    end else if (send) begin
      link_valid <= 1'b1;
      link_value <= sval;
    end else begin
      link_valid <= 1'b0;
      link_value <= ~link_value;
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench for the pin configuration bank
`timescale 1ns/10ps
module tb_top;
  import gpb_pkg::*;
  localparam logic [3:0] REV = 4'ha; // arbitrary revision code
  localparam logic [9:0] NOMAP = 10'h022; // unmapped word
  localparam logic [9:0] RA[7] = '{IDX_PIN0, IDX_PIN1_PIN2, IDX_PIN3, IDX_PIN5_PIN6,
    IDX_PIN7_PIN8, IDX_DUAL_RX, NOMAP};
  localparam logic [7:0] RV[7] = '{{REV, 4'h3}, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic aclk = '0, aresetn = '0, send = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rnd = 32'hb9dd;
  logic [3:0] s_axi_wstrb = '0, alt_func_out = '0, alt_pad_in = '0, alt_pad_out, alt_pad_oe_n;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  gpb_global_cfg_type global_cfg = '0;
  logic [7:0] func_out = '0, pad_in = '0, sval = '0, pad_out, pad_oe_n, link_value;
  logic link_valid, secondary_port_select;
  int n_errors = 0, total_checks = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  gpb_bank #(.REVISION(REV)) uut (.*);
  gpb_link_model link (.*);
  // free-running bus clock
  initial begin
    forever #50 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one write; response noted for the monitor
  // late holds bready low until the answer is seen, so the answer must stand a cycle
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [3:0] st = 4'h1,
    input logic [1:0] r = RESP_OKAY, input logic late = 1'b0);
    bit done;
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    repeat (60) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= !s_axi_bready;
      done = s_axi_bvalid && s_axi_bready;
      #1;
      if (done && !(s_axi_awvalid || s_axi_wvalid)) return;
    end
    n_errors++;
    summarize();
  endtask
  // one read; expected word noted for the monitor
  task automatic rd(input logic [9:0] i, input logic [11:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    rq.push_back({r, 20'h0, d});
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (60) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      #1;
      if (!(s_axi_arvalid || s_axi_rready)) return;
    end
    n_errors++;
    summarize();
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  // pad of one slot against its nibble, global setting functional
  task automatic pin(input int s, input logic [3:0] c, input logic r);
    logic d;
    d = !c[2] && c[1];
    check(pad_oe_n[s], d);
    if (!d) check(pad_out[s], c[2] ? r : (c[0] ? c[3] : func_out[s]));
  endtask
  // monitor: compare each bus answer with the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  initial begin
    logic [3:0] c;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 7; k++) rd(RA[k], RV[k], k == 6 ? RESP_SLVERR : RESP_OKAY);
    wr(IDX_PIN3, 8'hff);
    rd(IDX_PIN3, 12'h00f);
    wr(IDX_PIN0, 8'hf3);
    rd(IDX_PIN0, {REV, 4'h3});
    wr(NOMAP, 8'h5a, 4'h1, RESP_SLVERR);
    wr(IDX_PIN5_PIN6, 8'h55, 4'h0);
    rd(IDX_PIN5_PIN6, 12'h000);
    for (int m = 0; m < 4; m++) begin
      @(posedge aclk);
      func_out <= rnd[7:0];
      alt_func_out <= rnd[11:8];
      rnd = lfsr(rnd);
      c = {2'b10, 2'(m)};
      wr(IDX_PIN5_PIN6, {~c, c});
      wr(IDX_PIN7_PIN8, {c, ~c});
      wait_n(2);
      pin(4, c, 1'b0);
      pin(5, ~c, 1'b0);
      pin(6, ~c, 1'b0);
      pin(7, c, 1'b0);
    end
    wr(IDX_PIN5_PIN6, 8'h06);
    repeat (3) begin
      @(posedge aclk);
      send <= 1'b1;
      sval <= rnd[7:0];
      rnd = lfsr(rnd);
      @(posedge aclk);
      send <= 1'b0;
      wait_n(5);
      pin(4, 4'h6, sval[4]);
    end
    wr(IDX_PIN5_PIN6, 8'h09);
    @(posedge aclk);
    global_cfg <= 3'b110;
    wait_n(2);
    pin(4, 4'h9, 1'b0);
    check(pad_oe_n[5], 1'b1);
    @(posedge aclk);
    global_cfg <= 3'b101;
    wait_n(2);
    check({pad_oe_n[5], pad_out[5]}, 2'b01);
    @(posedge aclk);
    global_cfg <= 3'b000;
    wr(IDX_PIN0, 8'h09);
    wr(IDX_PIN1_PIN2, 8'h99);
    wr(IDX_PIN3, 8'h09, 4'h1, RESP_OKAY, 1'b1);
    wr(IDX_DUAL_RX, 8'h01);
    rd(IDX_DUAL_RX, 12'h001);
    wait_n(2);
    check({alt_pad_oe_n, alt_pad_out}, 8'h0f);
    check({pad_oe_n[3:0], pad_out[3:0]}, {4'h0, func_out[3:0]});
    for (int g = 0; g < 3; g++) begin
      @(posedge aclk);
      global_cfg <= g == 0 ? 3'b101 : (g == 1 ? 3'b010 : 3'b000);
      wait_n(2);
    end
    wr(IDX_DUAL_RX, 8'h00);
    wait_n(2);
    check({pad_oe_n[3:0], pad_out[3:0]}, 8'h0f);
    check({alt_pad_oe_n, alt_pad_out}, {4'h0, alt_func_out});
    @(posedge aclk);
    pad_in <= rnd[7:0];
    alt_pad_in <= rnd[11:8];
    wait_n(6);
    rd(IDX_PIN_LEVEL, rnd[11:0]);
    wait_n(3);
    summarize();
  end
endmodule
bind gpb_bank gpb_checker chk (.*);
